//--- design/pcr_pkg.sv
// Package with register map, field positions, reset values and timing for the control bank
package pcr_pkg;
	localparam logic [15:0] ADDR_FLAGS     = 16'hC000;
	localparam logic [15:0] ADDR_BASE_PTR  = 16'hC002;
	localparam logic [15:0] ADDR_REVISION  = 16'hC004;
	localparam logic [15:0] ADDR_DIVISOR   = 16'hC008;
	localparam logic [15:0] ADDR_POWER     = 16'hC00A;
	localparam logic [15:0] ADDR_CORE_STAT = 16'hC0F0;

	localparam int FLAG_ZERO    = 0;
	localparam int FLAG_CARRY   = 1;
	localparam int FLAG_OVERFLOW = 2;
	localparam int FLAG_NEGATIVE = 3;
	localparam int FLAG_GIE     = 4;

	localparam logic [15:0] BASE_PTR_RESET = 16'h0100;
	localparam logic [15:0] BASE_PTR_MASK  = 16'hFFF0;
	localparam logic [3:0]  DIVISOR_RESET  = 4'hF;
	localparam logic [15:0] DIVISOR_MASK   = 16'h000F;
	localparam logic [15:0] POWER_RESET    = 16'h0000;
	// Writable power bits: 15..11, 9, 8, 7, 4, 1, 0
	localparam logic [15:0] POWER_WR_MASK  = 16'hFB93;

	localparam int PWR_HALT       = 0;
	localparam int PWR_SLEEP      = 1;
	localparam int PWR_BOOST      = 2;
	localparam int PWR_GPI_WAKE   = 4;
	localparam int PWR_HOST_WAKE  = 7;
	localparam int PWR_SPI_WAKE   = 8;
	localparam int PWR_HSS_WAKE   = 9;
	localparam int PWR_OTG_WAKE   = 11;
	localparam int PWR_P1A_WAKE   = 12;
	localparam int PWR_P1B_WAKE   = 13;
	localparam int PWR_P2A_WAKE   = 14;
	localparam int PWR_P2B_WAKE   = 15;

	localparam int CLK_MHZ         = 100;
	localparam int WAKE_RESUME_NS  = 500000;
	// Longest time rounds down to whole cycles
	localparam int WAKE_RESUME_CYC = WAKE_RESUME_NS * CLK_MHZ / 1000;
	localparam int WAKE_DELAY_CYC  = 16;
endpackage

//--- design/pcr_clk_div.sv
// Core clock enable divider with glitch-free divisor update
`timescale 1ns/1ps
module pcr_clk_div #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] divisor,
	output logic                  core_en
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic [WIDTH-1:0] active;
		logic             en;
	} pcr_div_state_t;

	pcr_div_state_t st;
	pcr_div_state_t next_st;

	initial
	begin
		if (WIDTH < 1 || WIDTH > 8)
			$error("pcr_clk_div: WIDTH out of range");
	end

	// Divisor is only reloaded at a period boundary so no runt pulse appears
	always_comb
	begin
		next_st = st;
		next_st.en = 1'b0;
		if (run)
		begin
			if (st.count == st.active)
			begin
				next_st.count = '0;
				next_st.en = 1'b1;
				next_st.active = divisor; // [R17]
			end
			else
			begin
				next_st.count = st.count + 1'b1; // [R7]
			end
		end
	end

	// Counter freezes while run is low, keeping its value
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '{count: '0, active: '1, en: 1'b0};
		else
			st <= next_st;
	end

	assign core_en = st.en;
endmodule

//--- design/pcr_top.sv
// Processor control register bank: flags, base pointer, revision, divisor, power
// Functional notes
// R1 - Carry flag bit 1 tracks carry/borrow
// R2 - Zero flag bit 0 tracks zero result
// R3 - Base pointer bits 15:4, resets 0x0100
// R4 - Working register address = base OR num<<1
// R5 - Software writes zero to reserved bits
// R6 - Read-only revision word, writes ignored
// R7 - Core clock = system clock over field+1
// R8 - Divisor slows core only, peripherals undivided
// R9 - Power register selects sleep or halt
// R10 - Port 2B/2A transitions wake, no interrupt
// R11 - Power resets zero; boost RO; reserved fixed
// R12 - Sleep stops clock; resume within 0.5 ms
// R13 - Halt stops core; enabled interrupt ends it
// R14 - Boost status one when rails low
// R15 - Host port read wakes when enabled
// R16 - RO/reserved writes ignored; reserved read zero
// R17 - New divisor applied at period boundary
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module pcr_top #(
	parameter logic [15:0] REVISION       = 16'h0A5C, // Arbitrary value
	parameter int          WAKE_RESUME    = pcr_pkg::WAKE_RESUME_CYC,
	parameter int          WAKE_DELAY     = pcr_pkg::WAKE_DELAY_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        alu_update,
	input  wire logic        alu_carry,
	input  wire logic        alu_zero,
	input  wire logic        alu_overflow,
	input  wire logic        alu_negative,
	input  wire logic        global_int_en,
	input  wire logic [3:0]  reg_num,
	output logic      [15:0] working_reg_addr,
	input  wire logic        boost_rail_low,
	input  wire logic        port2b_activity,
	input  wire logic        port2a_activity,
	input  wire logic        port1b_activity,
	input  wire logic        port1a_activity,
	input  wire logic        otg_activity,
	input  wire logic        hss_activity,
	input  wire logic        spi_activity,
	input  wire logic        host_port_read,
	input  wire logic        gpi_activity,
	input  wire logic        int_pending,
	output logic             core_clk_en,
	output logic             periph_clk_en,
	output logic             sleeping,
	output logic             halted,
	output logic             wake_event
);
	typedef enum logic [1:0] {
		PCR_RUN,
		PCR_HALT,
		PCR_SLEEP,
		PCR_WAKING
	} pcr_mode_t;

	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] base_ptr;
		logic [3:0]  divisor;
		logic [15:0] power;
		pcr_mode_t   mode;
		logic [19:0] wake_cnt;
		logic [15:0] rdata;
		logic        wake_evt;
	} pcr_state_t;

	pcr_state_t  st;
	pcr_state_t  next_st;
	logic        rst_meta;
	logic        rst_n;
	logic        wake_hit;
	logic        div_run;

	initial
	begin
		if (WAKE_DELAY < 1 || WAKE_DELAY > WAKE_RESUME || WAKE_RESUME >= (1 << 20))
			$error("pcr_top: wake timing parameters out of range");
	end

	// Reset released through two flops; asserts at once
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Any enabled source ends sleep; port wakes raise no interrupt
	always_comb
	begin
		wake_hit = (st.power[pcr_pkg::PWR_P2B_WAKE] & port2b_activity) // [R10]
			| (st.power[pcr_pkg::PWR_P2A_WAKE] & port2a_activity) // [R10]
			| (st.power[pcr_pkg::PWR_P1B_WAKE] & port1b_activity)
			| (st.power[pcr_pkg::PWR_P1A_WAKE] & port1a_activity)
			| (st.power[pcr_pkg::PWR_OTG_WAKE] & otg_activity)
			| (st.power[pcr_pkg::PWR_HSS_WAKE] & hss_activity)
			| (st.power[pcr_pkg::PWR_SPI_WAKE] & spi_activity)
			| (st.power[pcr_pkg::PWR_HOST_WAKE] & host_port_read) // [R15]
			| (st.power[pcr_pkg::PWR_GPI_WAKE] & gpi_activity); // [R9]
	end

	// Register file, flags and power mode sequencing
	always_comb
	begin
		next_st = st;
		next_st.wake_evt = 1'b0;

		// Flags follow the ALU result of each executed instruction
		if (alu_update)
		begin
			next_st.flags[pcr_pkg::FLAG_CARRY] = alu_carry; // [R1]
			next_st.flags[pcr_pkg::FLAG_ZERO] = alu_zero; // [R2]
			next_st.flags[pcr_pkg::FLAG_OVERFLOW] = alu_overflow;
			next_st.flags[pcr_pkg::FLAG_NEGATIVE] = alu_negative;
		end
		next_st.flags[pcr_pkg::FLAG_GIE] = global_int_en;

		// Boost status is a live read-only mirror
		next_st.power[pcr_pkg::PWR_BOOST] = boost_rail_low; // [R14]

		if (wr)
		begin
			case (addr)
				pcr_pkg::ADDR_BASE_PTR:
				begin
					next_st.base_ptr = wdata & pcr_pkg::BASE_PTR_MASK; // [R3]
				end
				pcr_pkg::ADDR_DIVISOR:
				begin
					next_st.divisor = wdata[3:0]; // [R7]
				end
				pcr_pkg::ADDR_POWER:
				begin
					// Only writable bits land; boost and reserved stay put
					next_st.power = (wdata & pcr_pkg::POWER_WR_MASK)
						| (next_st.power & ~pcr_pkg::POWER_WR_MASK); // [R11] [R16]
				end
				default:
				begin
					// Flags and revision are read-only; writes dropped
					next_st.power = next_st.power; // [R6] [R16]
				end
			endcase
		end

		// Mode sequencing; sleep takes priority over halt
		case (st.mode)
			PCR_RUN:
			begin
				if (next_st.power[pcr_pkg::PWR_SLEEP])
					next_st.mode = PCR_SLEEP; // [R12]
				else if (next_st.power[pcr_pkg::PWR_HALT])
					next_st.mode = PCR_HALT; // [R13]
			end
			PCR_HALT:
			begin
				if (int_pending)
				begin
					next_st.mode = PCR_RUN; // [R13]
					next_st.power[pcr_pkg::PWR_HALT] = 1'b0;
				end
			end
			PCR_SLEEP:
			begin
				if (wake_hit)
				begin
					next_st.mode = PCR_WAKING; // [R12]
					next_st.wake_cnt = 20'(WAKE_DELAY - 1);
					next_st.wake_evt = 1'b1;
				end
			end
			PCR_WAKING:
			begin
				// Models clock restart; bounded well below the resume limit
				if (st.wake_cnt == '0)
				begin
					next_st.mode = PCR_RUN; // [R12]
					next_st.power[pcr_pkg::PWR_SLEEP] = 1'b0;
				end
				else
					next_st.wake_cnt = st.wake_cnt - 1'b1;
			end
			default:
				next_st.mode = PCR_RUN;
		endcase

		// Read data stands in the cycle after the strobe only
		next_st.rdata = 16'h0000;
		if (rd)
		begin
			case (addr)
				pcr_pkg::ADDR_FLAGS:     next_st.rdata = st.flags;
				pcr_pkg::ADDR_BASE_PTR:  next_st.rdata = st.base_ptr; // [R16]
				pcr_pkg::ADDR_REVISION:  next_st.rdata = REVISION; // [R6]
				pcr_pkg::ADDR_DIVISOR:   next_st.rdata = {12'h000, st.divisor}; // [R16]
				pcr_pkg::ADDR_POWER:     next_st.rdata = st.power;
				pcr_pkg::ADDR_CORE_STAT: next_st.rdata = {14'h0000, st.mode};
				default:                 next_st.rdata = 16'h0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st.flags <= 16'h0000;
			st.base_ptr <= pcr_pkg::BASE_PTR_RESET; // [R3]
			st.divisor <= pcr_pkg::DIVISOR_RESET; // [R7]
			st.power <= pcr_pkg::POWER_RESET; // [R11]
			st.mode <= PCR_RUN;
			st.wake_cnt <= 20'h00000;
			st.rdata <= 16'h0000;
			st.wake_evt <= 1'b0;
		end
		else
			st <= next_st;
	end

	// Core divider runs only when neither sleeping nor halted
	assign div_run = (st.mode == PCR_RUN);

	pcr_clk_div #(
		.WIDTH (4)
	) u_div (
		.clk     (clk),
		.rst_n   (rst_n),
		.run     (div_run),
		.divisor (st.divisor),
		.core_en (core_clk_en)
	);

	// Peripheral timing stays undivided, paused in sleep and through the wake delay
	assign periph_clk_en = (st.mode != PCR_SLEEP) && (st.mode != PCR_WAKING); // [R8] [R12]

	// Working register address: base high bits, number shifted, bit 0 low
	assign working_reg_addr = (st.base_ptr & pcr_pkg::BASE_PTR_MASK)
		| {11'h000, reg_num, 1'b0}; // [R4]

	assign rdata = st.rdata;
	assign sleeping = (st.mode == PCR_SLEEP);
	assign halted = (st.mode == PCR_HALT);
	assign wake_event = st.wake_evt;
endmodule

//--- test/pcr_top_assertions.sv
// Port checker for the processor control bank
`timescale 1ns/1ps
module pcr_top_chk #(
	parameter logic [15:0] REVISION   = 16'h0A5C, // Arbitrary value
	parameter int          WAKE_DELAY = 16
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [15:0] rdata,
	input  wire logic [3:0]  reg_num,
	input  wire logic [15:0] working_reg_addr,
	input  wire logic        int_pending,
	input  wire logic        core_clk_en,
	input  wire logic        periph_clk_en,
	input  wire logic        sleeping,
	input  wire logic        halted,
	input  wire logic        wake_event
);
	// Slack covers the event register and the mode change after the delay
	localparam int WK_MAX = WAKE_DELAY + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_reg_addr;
		working_reg_addr[4:0] == {reg_num, 1'b0};
	endproperty
	a_reg_addr: assert property (p_reg_addr) else $error("register address low bits");
	property p_rev;
		rd && addr == pcr_pkg::ADDR_REVISION |=> rdata == REVISION;
	endproperty
	a_rev: assert property (p_rev) else $error("revision word");
	property p_div_rsv;
		rd && addr == pcr_pkg::ADDR_DIVISOR |=> rdata[15:4] == 12'h000;
	endproperty
	a_div_rsv: assert property (p_div_rsv) else $error("divisor reserved bits");
	property p_pwr_rsv;
		rd && addr == pcr_pkg::ADDR_POWER |=> (rdata & 16'h0468) == 16'h0000;
	endproperty
	a_pwr_rsv: assert property (p_pwr_rsv) else $error("power reserved bits");
	property p_sleep_in;
		wr && addr == pcr_pkg::ADDR_POWER && wdata[1] && !sleeping && !halted
			|-> ##2 sleeping && !periph_clk_en;
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
	property p_sleep_still;
		sleeping && $past(sleeping) |-> !core_clk_en;
	endproperty
	a_sleep_still: assert property (p_sleep_still) else $error("core runs in sleep");
	property p_wake;
		$rose(wake_event) |-> ##[1:WK_MAX] periph_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("wake too slow");
	property p_halt_in;
		wr && addr == pcr_pkg::ADDR_POWER && wdata[1:0] == 2'b01 && !sleeping && !halted
			&& !int_pending |-> ##2 halted;
	endproperty
	a_halt_in: assert property (p_halt_in) else $error("halt not entered");
	property p_halt_run;
		halted && $past(halted) |-> !core_clk_en && periph_clk_en;
	endproperty
	a_halt_run: assert property (p_halt_run) else $error("halt clocks wrong");
	property p_halt_out;
		halted && int_pending |=> !halted;
	endproperty
	a_halt_out: assert property (p_halt_out) else $error("halt not ended");
	cover property (wake_event);
	cover property (halted && int_pending);
	cover property (rd && addr == pcr_pkg::ADDR_POWER);
endmodule

bind pcr_top pcr_top_chk #(.REVISION(REVISION), .WAKE_DELAY(WAKE_DELAY)) u_chk (
	.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .reg_num(reg_num), .working_reg_addr(working_reg_addr),
	.int_pending(int_pending), .core_clk_en(core_clk_en),
	.periph_clk_en(periph_clk_en), .sleeping(sleeping), .halted(halted),
	.wake_event(wake_event));

//--- test/tb_top.sv
// Self-checking bench for the processor control bank
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("FAIL %0t got %h exp %h", $time, a, b); end end
module tb_top;
	localparam logic [15:0] REV = 16'h1234; // Arbitrary value
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        alu_update = 1'b0;
	logic [4:0]  flg = 5'h00;
	logic [3:0]  reg_num = 4'hE;
	logic        boost = 1'b0;
	logic [8:0]  act = 9'h000;
	logic        int_pending = 1'b0;
	logic [15:0] rdata, wra;
	logic        core_en, periph_en, sleeping, halted, wake_event;
	int          err_total = 0;
	int          total_checks = 0;
	int          wbit [9] = '{15, 14, 13, 12, 11, 9, 8, 7, 4};
	pcr_top #(.REVISION(REV)) dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alu_update(alu_update),
		.alu_carry(flg[1]), .alu_zero(flg[0]), .alu_overflow(flg[2]),
		.alu_negative(flg[3]), .global_int_en(flg[4]), .reg_num(reg_num),
		.working_reg_addr(wra), .boost_rail_low(boost), .port2b_activity(act[0]),
		.port2a_activity(act[1]), .port1b_activity(act[2]), .port1a_activity(act[3]),
		.otg_activity(act[4]), .hss_activity(act[5]), .spi_activity(act[6]),
		.host_port_read(act[7]), .gpi_activity(act[8]), .int_pending(int_pending),
		.core_clk_en(core_en), .periph_clk_en(periph_en), .sleeping(sleeping),
		.halted(halted), .wake_event(wake_event));
	// 100 MHz system clock
	always #5 clk = ~clk;
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	// Four-state count, so an unknown enable cannot pass as zero pulses
	task automatic pulses(input int n, output logic [31:0] c);
		c = 32'h00000000;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			c += core_en;
		end
	endtask
	task automatic t_reset;
		rd_chk(pcr_pkg::ADDR_BASE_PTR, 16'h0100);
		rd_chk(pcr_pkg::ADDR_DIVISOR, 16'h000F);
		rd_chk(pcr_pkg::ADDR_POWER, 16'h0000);
		rd_chk(pcr_pkg::ADDR_REVISION, REV);
	endtask
	// Read-only, reserved and unmapped places must not change
	task automatic t_base;
		wr_reg(pcr_pkg::ADDR_BASE_PTR, 16'hABCF);
		rd_chk(pcr_pkg::ADDR_BASE_PTR, 16'hABC0);
		`CHK(wra, 16'hABDC)
		@(posedge clk);
		reg_num <= 4'h5;
		#1;
		`CHK(wra, 16'hABCA)
		wr_reg(pcr_pkg::ADDR_REVISION, 16'h0000);
		rd_chk(pcr_pkg::ADDR_REVISION, REV);
		rd_chk(16'hC006, 16'h0000);
		wr_reg(pcr_pkg::ADDR_DIVISOR, 16'hFFF7);
		rd_chk(pcr_pkg::ADDR_DIVISOR, 16'h0007);
	endtask
	task automatic t_flags;
		logic [4:0] fv [3] = '{5'h02, 5'h01, 5'h1D};
		foreach (fv[i])
		begin
			@(posedge clk);
			flg <= fv[i];
			alu_update <= 1'b1;
			@(posedge clk);
			alu_update <= 1'b0;
			rd_chk(pcr_pkg::ADDR_FLAGS, {11'h000, fv[i]});
		end
	endtask
	// A 48-cycle window holds a whole number of periods for each divisor
	task automatic t_div;
		int dv [3] = '{0, 3, 15};
		logic [31:0] c;
		foreach (dv[i])
		begin
			wr_reg(pcr_pkg::ADDR_DIVISOR, 16'(dv[i]));
			repeat (20) @(posedge clk);
			pulses(48, c);
			`CHK(c, 48 / (dv[i] + 1))
			`CHK(periph_en, 1'b1)
		end
	endtask
	task automatic t_wake;
		logic [15:0] en;
		logic        w;
		for (int i = 0; i < 9; i++)
		begin
			en = 16'h0001 << wbit[i];
			wr_reg(pcr_pkg::ADDR_POWER, en | 16'h0002);
			repeat (3) @(posedge clk);
			#1;
			`CHK(sleeping, 1'b1)
			`CHK(periph_en, 1'b0)
			@(posedge clk);
			act <= 9'h001 << ((i + 1) % 9);
			@(posedge clk);
			act <= 9'h000;
			repeat (4) @(posedge clk);
			#1;
			`CHK(sleeping, 1'b1)
			@(posedge clk);
			act <= 9'h001 << i;
			@(posedge clk);
			act <= 9'h000;
			// Wake pulse stands only in the cycle after the accepted event
			#1;
			w = wake_event;
			`CHK(w, 1'b1)
			`CHK(sleeping, 1'b0)
			for (int k = 0; k < 30 && !periph_en; k++)
			begin
				@(posedge clk);
				#1;
			end
			`CHK(periph_en, 1'b1)
			rd_chk(pcr_pkg::ADDR_POWER, en);
		end
	endtask
	task automatic t_power;
		logic [31:0] c;
		wr_reg(pcr_pkg::ADDR_POWER, 16'h0000);
		boost <= 1'b1;
		rd_chk(pcr_pkg::ADDR_POWER, 16'h0004);
		wr_reg(pcr_pkg::ADDR_POWER, 16'hFFFC);
		rd_chk(pcr_pkg::ADDR_POWER, 16'hFB94);
		boost <= 1'b0;
		wr_reg(pcr_pkg::ADDR_POWER, 16'h0001);
		repeat (3) @(posedge clk);
		pulses(32, c);
		`CHK(halted, 1'b1)
		`CHK(c, 0)
		`CHK(periph_en, 1'b1)
		rd_chk(pcr_pkg::ADDR_CORE_STAT, 16'h0001);
		int_pending <= 1'b1;
		repeat (2) @(posedge clk);
		int_pending <= 1'b0;
		#1;
		`CHK(halted, 1'b0)
		rd_chk(pcr_pkg::ADDR_POWER, 16'h0000);
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence: reset for 20 cycles, then the scenarios
	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_base();
		t_flags();
		t_div();
		t_wake();
		t_power();
		tally_and_finish();
	end
	// Watchdog, well beyond the few hundred cycles the scenarios need
	initial
	begin
		#100000;
		err_total++;
		tally_and_finish();
	end
endmodule
